// ### verification/misc_control_instr_exec_tb.sv
// self-checking bench for the misc control executer
`timescale 1ns/1ps
module misc_control_instr_exec_tb;
	logic                      clk, rstn, acc_load, wakeup, fire_adc, fire_wdt;
	misc_exec_pkg::instr_req_t instr;
	misc_exec_pkg::reg_req_t   reg_req;
	logic [3:0]                acc_load_val, acc;
	logic [7:0]                reg_rdata;
	logic                      ads, wfs, skip_next, pc_inc, conv, comp, done, wdf, wse, cer, bk, kp, irq;
	int                        miscompares = 0, n_tests = 0;
	misc_control_instr_exec misc_control_instr_exec_i (.clk(clk), .rstn(rstn), .instr(instr),
		.acc_load(acc_load), .acc_load_val(acc_load_val), .adc_done_set(ads),
		.wdt_flag_set(wfs), .wakeup(wakeup), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.acc(acc), .skip_next(skip_next), .pc_inc(pc_inc), .adc_start_conv(conv),
		.adc_start_comp(comp), .adc_done_flag(done), .watchdog_flag_first(wdf),
		.wdt_stop_enable(wse), .ceramic_clock_select(cer), .backup_active(bk),
		.detect_keep(kp), .irq(irq));
	periph_event_model periph_event_model_i (.clk(clk), .rstn(rstn), .fire_adc(fire_adc),
		.fire_wdt(fire_wdt), .adc_done_set(ads), .wdt_flag_set(wfs));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask
	task automatic run(input logic [9:0] op);
		@(posedge clk);
		instr <= '{1'b1, op};
		@(posedge clk);
		instr <= '0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		reg_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		reg_req <= '0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic fire(input logic a, input logic w);
		@(posedge clk);
		fire_adc <= a;
		fire_wdt <= w;
		@(posedge clk);
		fire_adc <= 1'b0;
		fire_wdt <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic load(input logic [3:0] v);
		@(posedge clk);
		acc_load <= 1'b1;
		acc_load_val <= v;
		@(posedge clk);
		acc_load <= 1'b0;
	endtask
	task automatic wake;
		@(posedge clk);
		wakeup <= 1'b1;
		@(posedge clk);
		wakeup <= 1'b0;
		#1;
		chk1(bk, 1'b0);
	endtask
	task automatic t_irq;
		fire(1'b1, 1'b0);
		chk1(irq, 1'b0);
		wr(misc_exec_pkg::REG_IRQ_EN, 8'h01);
		chk1(irq, 1'b1);
		rd(misc_exec_pkg::REG_IRQ_EN, 8'h01);
		rd(misc_exec_pkg::REG_IRQ_STAT, 8'h01);
		wr(misc_exec_pkg::REG_IRQ_CLR, 8'h01);
		chk1(irq, 1'b0);
		rd(4'hf, 8'h00);
		$display("irq test done");
	endtask
	task automatic t_adc;
		chk1(done, 1'b1);
		run(misc_exec_pkg::OPC_ADC_START);
		chk({5'h0, done, conv, comp}, 8'h02);
		wr(misc_exec_pkg::REG_ADC_CTRL, 8'h08);
		rd(misc_exec_pkg::REG_ADC_CTRL, 8'h08);
		run(misc_exec_pkg::OPC_ADC_START);
		chk({5'h0, done, conv, comp}, 8'h01);
		$display("adc test done");
	endtask
	task automatic t_add;
		load(4'h0);
		run(misc_exec_pkg::OPC_ADD_IMM | 10'h00f);
		chk({3'h0, skip_next, acc}, 8'h1f);
		run(misc_exec_pkg::OPC_ADD_IMM | 10'h001);
		chk({3'h0, skip_next, acc}, 8'h00);
		$display("add test done");
	endtask
	task automatic t_wdt;
		run(misc_exec_pkg::OPC_WDT_RST);
		chk1(skip_next, 1'b0);
		fire(1'b0, 1'b1);
		run(misc_exec_pkg::OPC_WDT_RST);
		chk({6'h0, skip_next, wdf}, 8'h02);
		run(misc_exec_pkg::OPC_CLK_CER);
		chk1(cer, 1'b1);
		run(misc_exec_pkg::OPC_CLK_RC);
		chk1(cer, 1'b0);
		chk1(wse, 1'b0);
		run(misc_exec_pkg::OPC_WDT_DIS);
		chk1(wse, 1'b1);
		rd(misc_exec_pkg::REG_STATUS, 8'h04);
		$display("watchdog and clock test done");
	endtask
	task automatic t_pwr;
		load(4'h5);
		run(misc_exec_pkg::OPC_NOP);
		chk({2'h0, pc_inc, skip_next, acc}, 8'h25);
		run(misc_exec_pkg::OPC_PWR_KEEP);
		chk({6'h0, bk, kp}, 8'h03);
		run(misc_exec_pkg::OPC_ADD_IMM);
		chk1(pc_inc, 1'b0);
		wake();
		run(misc_exec_pkg::OPC_PWR_SECOND);
		chk({6'h0, bk, kp}, 8'h02);
		wake();
		$display("power test done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		instr = '0;
		reg_req = '0;
		acc_load = 1'b0;
		acc_load_val = 4'h0;
		wakeup = 1'b0;
		fire_adc = 1'b0;
		fire_wdt = 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_irq();
		t_adc();
		t_add();
		t_wdt();
		t_pwr();
		report_and_stop();
	end
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule

// ### verification/misc_exec_chk_assertions.sv
// concurrent checks on the misc control executer ports
`timescale 1ns/1ps
module misc_exec_chk (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rstn,
	// stimulus side
	input wire misc_exec_pkg::instr_req_t instr,
	input wire misc_exec_pkg::reg_req_t   reg_req,
	input wire logic                      acc_load,
	input wire logic                      adc_done_set,
	input wire logic                      wdt_flag_set,
	input wire logic                      wakeup,
	// results
	input wire logic [3:0]                acc,
	input wire logic                      skip_next,
	input wire logic                      pc_inc,
	input wire logic                      adc_start_conv,
	input wire logic                      adc_start_comp,
	input wire logic                      adc_done_flag,
	input wire logic                      watchdog_flag_first,
	input wire logic                      wdt_stop_enable,
	input wire logic                      ceramic_clock_select,
	input wire logic                      backup_active,
	input wire logic                      detect_keep
);
	logic [9:0] op;
	logic       ex;
	logic       adc_go;
	logic       mode_ff;
	assign op = instr.opcode;
	assign ex = instr.valid && !backup_active;
	assign adc_go = ex && op == misc_exec_pkg::OPC_ADC_START && !adc_done_set;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= 1'b0;
		end else if (reg_req.we && reg_req.addr == misc_exec_pkg::REG_ADC_CTRL) begin
			mode_ff <= reg_req.wdata[misc_exec_pkg::ADC_MODE_BIT];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_add_sum: assert property (ex && op[9:4] == 6'h06
		|=> acc == $past(acc) + $past(op[3:0])) else $error("add sum wrong");
	a_add_skip: assert property (ex && op[9:4] == 6'h06
		|=> skip_next == ({1'b0, $past(acc)} + $past(op[3:0]) < 5'h10)) else $error("add skip wrong");
	a_adc_conv: assert property (adc_go && !mode_ff
		|=> adc_start_conv && !adc_start_comp && !adc_done_flag) else $error("conv start wrong");
	a_adc_comp: assert property (adc_go && mode_ff
		|=> adc_start_comp && !adc_start_conv && !adc_done_flag) else $error("comp start wrong");
	a_wdt_skip: assert property (ex && op == misc_exec_pkg::OPC_WDT_RST
		&& watchdog_flag_first && !wdt_flag_set |=> skip_next && !watchdog_flag_first)
		else $error("restart skip wrong");
	a_wdt_stop: assert property (ex && op == misc_exec_pkg::OPC_WDT_DIS
		|=> wdt_stop_enable) else $error("stop enable not set");
	a_stop_sticky: assert property (wdt_stop_enable
		|=> wdt_stop_enable) else $error("stop enable dropped");
	a_clk_cer: assert property (ex && op == misc_exec_pkg::OPC_CLK_CER
		|=> ceramic_clock_select) else $error("ceramic select wrong");
	a_clk_rc: assert property (ex && op == misc_exec_pkg::OPC_CLK_RC
		|=> !ceramic_clock_select) else $error("rc select wrong");
	a_pwr_keep: assert property (ex && op == misc_exec_pkg::OPC_PWR_KEEP && !wakeup
		|=> backup_active && detect_keep) else $error("power down wrong");
	a_nop_only: assert property (ex && op == misc_exec_pkg::OPC_NOP && !acc_load
		|=> pc_inc && !skip_next && $stable(acc)) else $error("nop changed state");
	c_adc_comp: cover property (adc_go && mode_ff);
	c_wdt_stop: cover property (ex && op == misc_exec_pkg::OPC_WDT_DIS);
	c_wdt_skip: cover property (ex && op == misc_exec_pkg::OPC_WDT_RST && watchdog_flag_first);
	c_add_ovf: cover property (ex && op[9:4] == 6'h06 && acc == 4'hf && op[3:0] != 4'h0);
endmodule
bind misc_control_instr_exec misc_exec_chk misc_exec_chk_i (.*);

// ### verification/periph_event_model.sv
// peripheral event source beside the executer
`timescale 1ns/1ps
module periph_event_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// requests from bench
	input  wire logic fire_adc,
	input  wire logic fire_wdt,
	// events into the executer
	output logic      adc_done_set,
	output logic      wdt_flag_set
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			adc_done_set <= 1'b0;
			wdt_flag_set <= 1'b0;
		end else begin
			adc_done_set <= fire_adc;
			wdt_flag_set <= fire_wdt;
		end
	end
endmodule

// ### verilog/misc_control_instr_exec.sv
// executer for misc control, add-immediate and a-d start instructions
`timescale 1ns/1ps

// What this block does
// - keep-detect power-down enters backup, detector on
// - watchdog restart skips on flag, then clears
// - watchdog disable enables the stop capability
// - ceramic select picks ceramic resonator clock
// - rc select picks rc oscillator clock
// - add immediate 0..15 into accumulator
// - add immediate leaves carry flag alone
// - add immediate skips next unless overflow
// - adc start clears done, mode 0 converts
// - adc start clears done, mode 1 compares
// - mode select sits at control bit 3
module misc_control_instr_exec (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rstn,
	// instruction from sequencer
	input  wire misc_exec_pkg::instr_req_t          instr,
	// accumulator load from other instructions
	input  wire logic                               acc_load,
	input  wire logic [misc_exec_pkg::ACC_W-1:0]    acc_load_val,
	// peripheral events
	input  wire logic                               adc_done_set,
	input  wire logic                               wdt_flag_set,
	input  wire logic                               wakeup,
	// register port
	input  wire misc_exec_pkg::reg_req_t            reg_req,
	output logic [misc_exec_pkg::DATA_W-1:0]        reg_rdata,
	// core side
	output logic [misc_exec_pkg::ACC_W-1:0]         acc,
	output logic                                    skip_next,
	output logic                                    pc_inc,
	// a-d converter
	output logic                                    adc_start_conv,
	output logic                                    adc_start_comp,
	output logic                                    adc_done_flag,
	// watchdog and clock generator
	output logic                                    watchdog_flag_first,
	output logic                                    wdt_stop_enable,
	output logic                                    ceramic_clock_select,
	// power control
	output logic                                    backup_active,
	output logic                                    detect_keep,
	// interrupt
	output logic                                    irq
);

	typedef struct packed {
		logic [misc_exec_pkg::ACC_W-1:0]  acc;
		logic                             skip;
		logic                             pc_inc;
		logic                             start_conv;
		logic                             start_comp;
		logic                             adc_done;
		logic [misc_exec_pkg::ACC_W-1:0]  adc_ctrl;
		logic                             wdt_flag;
		logic                             wdt_stop_en;
		logic                             clk_cer;
		logic                             backup;
		logic                             detect_keep;
		logic [misc_exec_pkg::IRQ_W-1:0]  irq_stat;
		logic [misc_exec_pkg::IRQ_W-1:0]  irq_en;
		logic                             irq;
		logic [misc_exec_pkg::DATA_W-1:0] rdata;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	function automatic logic opc_is(input logic [misc_exec_pkg::OPC_W-1:0] opc,
			input logic [misc_exec_pkg::OPC_W-1:0] code);
		opc_is = (opc == code);
	endfunction

	function automatic logic is_add_imm(input logic [misc_exec_pkg::OPC_W-1:0] opc);
		is_add_imm = ((opc & misc_exec_pkg::OPC_ADD_MASK) == misc_exec_pkg::OPC_ADD_IMM);
	endfunction

	// zero-extend narrow fields onto the read bus
	function automatic logic [misc_exec_pkg::DATA_W-1:0] pad_acc(
			input logic [misc_exec_pkg::ACC_W-1:0] v);
		pad_acc = {{(misc_exec_pkg::DATA_W-misc_exec_pkg::ACC_W){1'b0}}, v};
	endfunction

	function automatic logic [misc_exec_pkg::DATA_W-1:0] pad_irq(
			input logic [misc_exec_pkg::IRQ_W-1:0] v);
		pad_irq = {{(misc_exec_pkg::DATA_W-misc_exec_pkg::IRQ_W){1'b0}}, v};
	endfunction

	// sticky status, a set beats a clear in one cycle
	function automatic logic [misc_exec_pkg::IRQ_W-1:0] sticky(
			input logic [misc_exec_pkg::IRQ_W-1:0] stat,
			input logic [misc_exec_pkg::IRQ_W-1:0] clr,
			input logic [misc_exec_pkg::IRQ_W-1:0] ev);
		sticky = (stat & ~clr) | ev;
	endfunction

	// instruction classes after decode
	typedef enum logic [3:0] {
		OP_OTHER      = 4'h0,
		OP_NOP        = 4'h1,
		OP_ADD_IMM    = 4'h2,
		OP_ADC_START  = 4'h3,
		OP_WDT_RST    = 4'h4,
		OP_WDT_DIS    = 4'h5,
		OP_CLK_CER    = 4'h6,
		OP_CLK_RC     = 4'h7,
		OP_PWR_KEEP   = 4'h8,
		OP_PWR_SECOND = 4'h9
	} op_class_t;

	// opcode to class, unknown codes fall to other
	function automatic op_class_t decode(input logic [misc_exec_pkg::OPC_W-1:0] opc);
		op_class_t kind;
		kind = OP_OTHER;
		if (is_add_imm(opc)) begin
			kind = OP_ADD_IMM;
		end else if (opc_is(opc, misc_exec_pkg::OPC_NOP)) begin
			kind = OP_NOP;
		end else if (opc_is(opc, misc_exec_pkg::OPC_ADC_START)) begin
			kind = OP_ADC_START;
		end else if (opc_is(opc, misc_exec_pkg::OPC_WDT_RST)) begin
			kind = OP_WDT_RST;
		end else if (opc_is(opc, misc_exec_pkg::OPC_WDT_DIS)) begin
			kind = OP_WDT_DIS;
		end else if (opc_is(opc, misc_exec_pkg::OPC_CLK_CER)) begin
			kind = OP_CLK_CER;
		end else if (opc_is(opc, misc_exec_pkg::OPC_CLK_RC)) begin
			kind = OP_CLK_RC;
		end else if (opc_is(opc, misc_exec_pkg::OPC_PWR_KEEP)) begin
			kind = OP_PWR_KEEP;
		end else if (opc_is(opc, misc_exec_pkg::OPC_PWR_SECOND)) begin
			kind = OP_PWR_SECOND;
		end
		decode = kind;
	endfunction

	logic                                  exec;
	logic [misc_exec_pkg::OPC_W-1:0]       opc;
	logic [misc_exec_pkg::ACC_W:0]         sum;
	logic [misc_exec_pkg::IRQ_W-1:0]       irq_set;
	logic [misc_exec_pkg::IRQ_W-1:0]       irq_clr;
	logic [misc_exec_pkg::DATA_W-1:0]      status_word;
	op_class_t                             cls;

	always_comb begin
		nxt_st = st_ff;
		opc = instr.opcode;
		cls = decode(opc);
		exec = instr.valid && !st_ff.backup;
		sum = {1'b0, st_ff.acc} + {1'b0, opc[misc_exec_pkg::ACC_W-1:0]};
		irq_set = '0;
		irq_clr = '0;
		status_word = '0;

		// pulses default low
		nxt_st.skip = 1'b0;
		nxt_st.pc_inc = 1'b0;
		nxt_st.start_conv = 1'b0;
		nxt_st.start_comp = 1'b0;

		if (acc_load) begin
			nxt_st.acc = acc_load_val;
		end

		if (exec) begin
			nxt_st.pc_inc = 1'b1;
			// one action per decoded class
			unique case (cls)
				OP_ADD_IMM: begin
					nxt_st.acc = sum[misc_exec_pkg::ACC_W-1:0];
					nxt_st.skip = !sum[misc_exec_pkg::ACC_W];
				end
				OP_ADC_START: begin
					nxt_st.adc_done = 1'b0;
					if (st_ff.adc_ctrl[misc_exec_pkg::ADC_MODE_BIT]) begin
						nxt_st.start_comp = 1'b1;
					end else begin
						nxt_st.start_conv = 1'b1;
					end
				end
				OP_WDT_RST: begin
					if (st_ff.wdt_flag) begin
						nxt_st.skip = 1'b1;
						nxt_st.wdt_flag = 1'b0;
					end
				end
				OP_WDT_DIS: begin
					nxt_st.wdt_stop_en = 1'b1;
				end
				OP_CLK_CER: begin
					nxt_st.clk_cer = 1'b1;
				end
				OP_CLK_RC: begin
					nxt_st.clk_cer = 1'b0;
				end
				OP_PWR_KEEP: begin
					nxt_st.backup = 1'b1;
					nxt_st.detect_keep = 1'b1;
					irq_set[misc_exec_pkg::IRQ_BACKUP] = 1'b1;
				end
				OP_PWR_SECOND: begin
					nxt_st.backup = 1'b1;
					nxt_st.detect_keep = 1'b0;
					irq_set[misc_exec_pkg::IRQ_BACKUP] = 1'b1;
				end
				OP_NOP, OP_OTHER: begin
					// only the program counter moves
				end
			endcase
		end

		// wake leaves backup
		if (st_ff.backup && wakeup) begin
			nxt_st.backup = 1'b0;
			nxt_st.detect_keep = 1'b0;
		end

		// peripheral sets win over instruction clears
		if (adc_done_set) begin
			nxt_st.adc_done = 1'b1;
			irq_set[misc_exec_pkg::IRQ_ADC_DONE] = 1'b1;
		end
		if (wdt_flag_set) begin
			nxt_st.wdt_flag = 1'b1;
			irq_set[misc_exec_pkg::IRQ_WDT_FLAG] = 1'b1;
		end

		// register writes
		if (reg_req.we) begin
			unique case (reg_req.addr)
				misc_exec_pkg::REG_ADC_CTRL: begin
					nxt_st.adc_ctrl = reg_req.wdata[misc_exec_pkg::ACC_W-1:0];
				end
				misc_exec_pkg::REG_IRQ_EN: begin
					nxt_st.irq_en = reg_req.wdata[misc_exec_pkg::IRQ_W-1:0];
				end
				misc_exec_pkg::REG_IRQ_CLR: begin
					irq_clr = reg_req.wdata[misc_exec_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		nxt_st.irq_stat = sticky(st_ff.irq_stat, irq_clr, irq_set);
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);

		// register reads, data next cycle only
		status_word = {2'b00, st_ff.detect_keep, st_ff.backup, st_ff.clk_cer,
			st_ff.wdt_stop_en, st_ff.wdt_flag, st_ff.adc_done};
		nxt_st.rdata = '0;
		if (reg_req.re) begin
			unique case (reg_req.addr)
				misc_exec_pkg::REG_STATUS: begin
					nxt_st.rdata = status_word;
				end
				misc_exec_pkg::REG_ADC_CTRL: begin
					nxt_st.rdata = pad_acc(st_ff.adc_ctrl);
				end
				misc_exec_pkg::REG_IRQ_STAT: begin
					nxt_st.rdata = pad_irq(st_ff.irq_stat);
				end
				misc_exec_pkg::REG_IRQ_EN: begin
					nxt_st.rdata = pad_irq(st_ff.irq_en);
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.acc <= misc_exec_pkg::ACC_RST;
			st_ff.adc_ctrl <= misc_exec_pkg::ADC_CTRL_RST;
			st_ff.clk_cer <= misc_exec_pkg::CLK_CER_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from state
	assign reg_rdata            = st_ff.rdata;
	assign acc                  = st_ff.acc;
	assign skip_next            = st_ff.skip;
	assign pc_inc               = st_ff.pc_inc;
	assign adc_start_conv       = st_ff.start_conv;
	assign adc_start_comp       = st_ff.start_comp;
	assign adc_done_flag        = st_ff.adc_done;
	assign watchdog_flag_first  = st_ff.wdt_flag;
	assign wdt_stop_enable      = st_ff.wdt_stop_en;
	assign ceramic_clock_select = st_ff.clk_cer;
	assign backup_active        = st_ff.backup;
	assign detect_keep          = st_ff.detect_keep;
	assign irq                  = st_ff.irq;

endmodule

// ### verilog/misc_exec_pkg.sv
// constants, opcodes and carrier types for the misc control executer
package misc_exec_pkg;
	// word widths
	localparam int OPC_W  = 10;
	localparam int ACC_W  = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int IRQ_W  = 3;

	// opcodes
	localparam logic [OPC_W-1:0] OPC_NOP        = 10'h000;
	localparam logic [OPC_W-1:0] OPC_ADD_IMM    = 10'h060;
	localparam logic [OPC_W-1:0] OPC_ADD_MASK   = 10'h3f0;
	localparam logic [OPC_W-1:0] OPC_ADC_START  = 10'h29f;
	localparam logic [OPC_W-1:0] OPC_PWR_KEEP   = 10'h002;
	localparam logic [OPC_W-1:0] OPC_PWR_SECOND = 10'h008;
	localparam logic [OPC_W-1:0] OPC_WDT_DIS    = 10'h29c;
	localparam logic [OPC_W-1:0] OPC_WDT_RST    = 10'h2a0;
	localparam logic [OPC_W-1:0] OPC_CLK_CER    = 10'h29a;
	localparam logic [OPC_W-1:0] OPC_CLK_RC     = 10'h29b;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_ADC_CTRL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 4'h3;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 4'h4;

	// field positions
	localparam int ADC_MODE_BIT = 3;
	localparam int IRQ_ADC_DONE = 0;
	localparam int IRQ_WDT_FLAG = 1;
	localparam int IRQ_BACKUP   = 2;

	// reset values
	localparam logic [ACC_W-1:0] ACC_RST      = 4'h0;
	localparam logic [ACC_W-1:0] ADC_CTRL_RST = 4'h0;
	localparam logic             CLK_CER_RST  = 1'h0;

	typedef struct packed {
		logic             valid;
		logic [OPC_W-1:0] opcode;
	} instr_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} reg_req_t;
endpackage
